//--- hwrt_pkg.sv
// Constants, encodings and the state type shared by the halt, wake-up,
// reset and timebase block and its port-wake synchroniser.
// Assumes a single 40 MHz system clock and a slow timing tick.
package hwrt_pkg;
	// Start-up delay: system clock periods, one ref_clk cycle per period.
	localparam int unsigned SST_PERIODS = 1024;
	localparam int unsigned CLK_PER_PERIOD = 1;
	localparam int unsigned SST_CYCLES = SST_PERIODS * CLK_PER_PERIOD;
	localparam logic [10:0] SST_LOAD = 11'(SST_CYCLES - 1);
	// Interrupt call is held off this many cycles after a wake.
	localparam logic [1:0] CALL_HOLD = 2'h2;
	// Build-time options.
	localparam logic [3:0] TB_EXP = 4'hC;
	localparam int WDT_EXP = 15;
	localparam logic [7:0] PA_WAKE_EN = 8'hFF;
	localparam logic SYS_OSC_32K = 1'b0;
	localparam logic LCD_SLOW_SRC = 1'b1;
	// Register indices; the byte address is four times the index.
	localparam logic [5:0] IDX_RTC_CONTROL = 6'h09;
	localparam logic [5:0] IDX_INTERRUPT_CONTROL_ONE = 6'h1E;
	localparam logic [5:0] IDX_CMD = 6'h20;
	localparam logic [5:0] IDX_STAT = 6'h21;
	localparam logic [7:0] ADDR_RTC_CONTROL = {IDX_RTC_CONTROL, 2'h0};
	localparam logic [7:0] ADDR_INTERRUPT_CONTROL_ONE = {IDX_INTERRUPT_CONTROL_ONE, 2'h0};
	localparam logic [7:0] ADDR_CMD = {IDX_CMD, 2'h0};
	localparam logic [7:0] ADDR_STAT = {IDX_STAT, 2'h0};
	// Field positions and reset values.
	localparam int INTERRUPT_CONTROL_ONE_ETBI = 1;
	localparam int INTERRUPT_CONTROL_ONE_ERTI = 2;
	localparam int INTERRUPT_CONTROL_ONE_TBF = 5;
	localparam int INTERRUPT_CONTROL_ONE_RTF = 6;
	localparam logic [7:0] INTERRUPT_CONTROL_ONE_MASK = 8'h77;
	localparam logic [7:0] INTERRUPT_CONTROL_ONE_RST = 8'h00;
	localparam logic [7:0] RTC_CONTROL_MASK = 8'h3F;
	localparam logic [7:0] RTC_CONTROL_RST = 8'h07;
	localparam int CMD_HALT = 0;
	localparam int CMD_CLRWDT = 1;
	localparam int STAT_TO = 0;
	localparam int STAT_PDF = 1;
	localparam int STAT_HALT = 2;
	localparam int STAT_SST = 3;
	localparam logic [7:0] VEC_TB = 8'h14;
	localparam logic [7:0] VEC_RTC = 8'h18;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [2:0] SEL_NONE = 3'h0;
	localparam logic [2:0] SEL_RTC_CONTROL = 3'h1;
	localparam logic [2:0] SEL_INTERRUPT_CONTROL_ONE = 3'h2;
	localparam logic [2:0] SEL_CMD = 3'h3;
	localparam logic [2:0] SEL_STAT = 3'h4;
	typedef enum logic [1:0] {ST_RUN, ST_HALT, ST_SST} hwrt_state_t;
endpackage : hwrt_pkg

//--- hwrt_wake_sync.sv
// Port A falling-edge wake detector with a two-stage synchroniser.
// Assumes pins are asynchronous and idle high; one ref_clk domain.
`timescale 1ns/1ps
`default_nettype none
module hwrt_wake_sync (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic [7:0] pinIn,
	output logic wakeEdge
);
	import hwrt_pkg::*;

	logic [7:0] stage1_reg;
	logic [7:0] stage2_reg;
	logic [7:0] stage3_reg;
	logic [7:0] fall;
	logic wake_next;

	// Each pin has its own enable; edge taken past the second stage.
	for (genvar i = 0; i < 8; i++) begin : g_bit
		assign fall[i] = PA_WAKE_EN[i] & stage3_reg[i] & ~stage2_reg[i];
	end

	// Any enabled falling edge requests a wake.
	always_comb begin
		wake_next = |fall;
	end

	// The first stage feeds only the second, so metastability stays put.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			stage1_reg <= 8'hFF;
			stage2_reg <= 8'hFF;
			stage3_reg <= 8'hFF;
			wakeEdge <= 1'b0;
		end else begin
			stage1_reg <= pinIn;
			stage2_reg <= stage1_reg;
			stage3_reg <= stage2_reg;
			wakeEdge <= wake_next;
		end
	end
endmodule : hwrt_wake_sync
`default_nettype wire

//--- hwrt_halt_wake_reset.sv
// Halt, wake-up and reset sequencer with the timebase and RTC divider.
// Assumes an AXI4-Lite master, a CPU that obeys cpuRun and the reset
// pulses, and slowTick as a one-cycle enable from the slow oscillator.
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Timebase period is build option 2^12..2^15.
// - Timebase timeout sets flag, calls 14H.
// - Three-bit field selects RTC divide 2^8..2^15.
// - RTC timeout sets flag, calls 18H.
// - Halt stops system oscillator, slow keeps running.
// - Halt keeps RAM, registers and port states.
// - Halt entry clears and restarts watchdog.
// - Halt sets power-down flag, clears timeout.
// - Power-up, clear-watchdog clear POWER_DOWN_FLAG; overflow sets TO.
// - Reset, interrupt, port edge, watchdog leave halt.
// - Each port A bit has wake enable.
// - Watchdog wake is warm reset, sets TO.
// - Port wake resumes at next instruction.
// - Interrupt wake calls only if enabled, stack free.
// - Flag set before halt cannot wake.
// - 1024-cycle start-up delay on wake, power-up.
// - Next instruction immediate; call delayed beyond one cycle.
// - TO and POWER_DOWN_FLAG encode the reset cause.
// - Chip reset clears PC, interrupts, ports, stack.
// - Chip reset clears counters; watchdog restarts.
// - LCD clock runs in halt from slow source.
// - Request flags stay until serviced or cleared.
// - Slow crystal system clock keeps running in halt.
module hwrt_halt_wake_reset (
	input wire logic ref_clk,
	input wire logic srst,
	input wire logic externalResetPinN,
	input wire logic [7:0] portAPins,
	input wire logic extIrqEvent,
	input wire logic globalIrqEn,
	input wire logic stackFull,
	input wire logic slowTick,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic sysOscRun,
	output logic lcdClkRun,
	output logic cpuRun,
	output logic ioHold,
	output logic chipReset,
	output logic warmReset,
	output logic resumeNext,
	output logic irqCall,
	output logic [7:0] irqVector
);
	import hwrt_pkg::*;

	// Maps a byte address to a register select; shared by both paths.
	function automatic logic [2:0] regSel(input logic [7:0] a);
		case (a)
			ADDR_RTC_CONTROL: regSel = SEL_RTC_CONTROL;
			ADDR_INTERRUPT_CONTROL_ONE: regSel = SEL_INTERRUPT_CONTROL_ONE;
			ADDR_CMD: regSel = SEL_CMD;
			ADDR_STAT: regSel = SEL_STAT;
			default: regSel = SEL_NONE;
		endcase
	endfunction : regSel

	// True on the divider count where the low e bits are all ones.
	function automatic logic divHit(input logic [14:0] d,
			input logic [3:0] e);
		logic [15:0] m;
		m = (16'h0001 << e) - 16'h0001;
		divHit = &(d | ~m[14:0]);
	endfunction : divHit

	// Bus state.
	logic awHeld_reg, awHeld_next, wHeld_reg, wHeld_next;
	logic [7:0] awAddr_reg, awAddr_next;
	logic [7:0] wData_reg, wData_next;
	logic wEn_reg, wEn_next;
	logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [2:0] wrSel, rdSel;
	logic wrFire, wrEn;
	logic [31:0] statWord;

	// Core state.
	hwrt_state_t state_reg, state_next;
	logic [10:0] sstCnt_reg, sstCnt_next;
	logic [WDT_EXP-1:0] wdt_reg, wdt_next;
	logic [14:0] div_reg, div_next;
	logic to_reg, to_next, pdf_reg, pdf_next;
	logic [7:0] rtc_control_reg, rtc_control_next, intc_reg, intc_next;
	logic chipRst_reg, chipRst_next, warmRst_reg, warmRst_next;
	logic call_reg, call_next, resume_reg, resume_next;
	logic [7:0] vec_reg, vec_next;
	logic irqWake_reg, irqWake_next;
	logic [1:0] hold_reg, hold_next;

	logic paWake, resetEvt, wdtOvf, tbSet, rtcSet, irqTaken;
	logic haltCmd, clrCmd, canCall, wakeAny;
	logic tbFresh, rtcFresh;

	hwrt_wake_sync u_wake (
		.ref_clk(ref_clk),
		.srst(srst),
		.pinIn(portAPins),
		.wakeEdge(paWake)
	);

	// Event decode; timers run on the slow tick, so also during halt.
	assign resetEvt = ~externalResetPinN;
	assign wdtOvf = slowTick & (&wdt_reg);
	assign tbSet = slowTick & divHit(div_reg, TB_EXP);
	assign rtcSet = slowTick & divHit(div_reg, {1'b1, rtc_control_reg[2:0]});
	// A timeout is fresh only while its flag is still clear.
	assign tbFresh = tbSet & ~intc_reg[INTERRUPT_CONTROL_ONE_TBF];
	assign rtcFresh = rtcSet & ~intc_reg[INTERRUPT_CONTROL_ONE_RTF];
	assign irqTaken = ((tbFresh & intc_reg[INTERRUPT_CONTROL_ONE_ETBI])
		| (rtcFresh & intc_reg[INTERRUPT_CONTROL_ONE_ERTI])) & globalIrqEn & ~stackFull;
	// Only fresh events wake; a flag left pending from before is ignored.
	assign wakeAny = paWake | extIrqEvent | tbFresh | rtcFresh;
	assign wrSel = regSel(awAddr_reg);
	assign rdSel = regSel(s_axi_araddr);
	assign wrFire = awHeld_reg & wHeld_reg & ~bvalid_reg;
	assign wrEn = wrFire & wEn_reg;
	assign haltCmd = wrEn && wrSel == SEL_CMD && wData_reg[CMD_HALT];
	assign clrCmd = wrEn && wrSel == SEL_CMD && wData_reg[CMD_CLRWDT];
	assign canCall = state_reg == ST_RUN && hold_reg == 2'h0
		&& globalIrqEn && !stackFull;

	// Handshake outputs are decoded from the holding flags.
	assign s_axi_awready = ~awHeld_reg & ~bvalid_reg;
	assign s_axi_wready = ~wHeld_reg & ~bvalid_reg;
	assign s_axi_arready = ~rvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rdata = rdata_reg;
	assign s_axi_rresp = rresp_reg;

	// Oscillator, LCD and port-hold controls follow the state.
	assign sysOscRun = (state_reg != ST_HALT) | SYS_OSC_32K;
	assign lcdClkRun = (state_reg != ST_HALT) | LCD_SLOW_SRC;
	assign ioHold = state_reg == ST_HALT;
	assign cpuRun = state_reg == ST_RUN;
	assign chipReset = chipRst_reg;
	assign warmReset = warmRst_reg;
	assign resumeNext = resume_reg;
	assign irqCall = call_reg;
	assign irqVector = vec_reg;

	// Status word gathers flags and sequencer state for reads.
	always_comb begin
		statWord = 32'h0000_0000;
		statWord[STAT_TO] = to_reg;
		statWord[STAT_PDF] = pdf_reg;
		statWord[STAT_HALT] = state_reg == ST_HALT;
		statWord[STAT_SST] = state_reg == ST_SST;
	end

	// Bus slave: address and data in either order, one write answer.
	always_comb begin
		awHeld_next = awHeld_reg;
		awAddr_next = awAddr_reg;
		wHeld_next = wHeld_reg;
		wData_next = wData_reg;
		wEn_next = wEn_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			awHeld_next = 1'b1;
			awAddr_next = s_axi_awaddr;
		end
		// Registers are one byte wide, so only lane 0 matters.
		if (s_axi_wvalid && s_axi_wready) begin
			wHeld_next = 1'b1;
			wData_next = s_axi_wdata[7:0];
			wEn_next = s_axi_wstrb[0];
		end
		if (wrFire) begin
			awHeld_next = 1'b0;
			wHeld_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = (wrSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rresp_next = RESP_OKAY;
			case (rdSel)
				SEL_RTC_CONTROL: rdata_next = 32'(rtc_control_reg);
				SEL_INTERRUPT_CONTROL_ONE: rdata_next = 32'(intc_reg);
				SEL_CMD: rdata_next = 32'h0000_0000;
				SEL_STAT: rdata_next = statWord;
				default: begin
					rdata_next = 32'h0000_0000;
					rresp_next = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (srst) begin
			awHeld_reg <= 1'b0;
			awAddr_reg <= 8'h00;
			wHeld_reg <= 1'b0;
			wData_reg <= 8'h00;
			wEn_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= RESP_OKAY;
			rvalid_reg <= 1'b0;
			rresp_reg <= RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
		end else begin
			awHeld_reg <= awHeld_next;
			awAddr_reg <= awAddr_next;
			wHeld_reg <= wHeld_next;
			wData_reg <= wData_next;
			wEn_reg <= wEn_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
		end
	end

	// Sequencer, counters and flags. Hardware sets are applied after all but chip reset so
	// that an event in the cycle of a clear or a service is never lost.
	always_comb begin
		state_next = state_reg;
		sstCnt_next = sstCnt_reg;
		wdt_next = wdt_reg;
		div_next = div_reg;
		to_next = to_reg;
		pdf_next = pdf_reg;
		rtc_control_next = rtc_control_reg;
		intc_next = intc_reg;
		chipRst_next = 1'b0;
		warmRst_next = 1'b0;
		call_next = 1'b0;
		resume_next = 1'b0;
		vec_next = vec_reg;
		irqWake_next = irqWake_reg;
		hold_next = (hold_reg != 2'h0) ? hold_reg - 2'h1 : 2'h0;
		if (slowTick) begin
			wdt_next = wdt_reg + 1'b1;
			div_next = div_reg + 15'h0001;
		end
		if (wrEn && wrSel == SEL_RTC_CONTROL) begin
			rtc_control_next = wData_reg & RTC_CONTROL_MASK;
		end
		if (wrEn && wrSel == SEL_INTERRUPT_CONTROL_ONE) begin
			intc_next = wData_reg & INTERRUPT_CONTROL_ONE_MASK;
		end
		if (clrCmd) begin
			wdt_next = '0;
			pdf_next = 1'b0;
		end
		// Service clears the flag; timebase has the higher priority.
		if (canCall && intc_reg[INTERRUPT_CONTROL_ONE_TBF] && intc_reg[INTERRUPT_CONTROL_ONE_ETBI]) begin
			call_next = 1'b1;
			vec_next = VEC_TB;
			intc_next[INTERRUPT_CONTROL_ONE_TBF] = 1'b0;
		end else if (canCall && intc_reg[INTERRUPT_CONTROL_ONE_RTF]
				&& intc_reg[INTERRUPT_CONTROL_ONE_ERTI]) begin
			call_next = 1'b1;
			vec_next = VEC_RTC;
			intc_next[INTERRUPT_CONTROL_ONE_RTF] = 1'b0;
		end
		case (state_reg)
			ST_RUN: begin
				if (resetEvt) begin
					chipRst_next = 1'b1;
				end else if (wdtOvf) begin
					chipRst_next = 1'b1;
					to_next = 1'b1;
				end else if (haltCmd) begin
					state_next = ST_HALT;
					pdf_next = 1'b1;
					to_next = 1'b0;
					wdt_next = '0;
				end
			end
			ST_HALT: begin
				if (resetEvt) begin
					chipRst_next = 1'b1;
					state_next = ST_SST;
					sstCnt_next = SST_LOAD;
				end else if (wdtOvf) begin
					warmRst_next = 1'b1;
					to_next = 1'b1;
					wdt_next = '0;
					state_next = ST_SST;
					sstCnt_next = SST_LOAD;
				end else if (wakeAny) begin
					irqWake_next = irqTaken;
					state_next = ST_SST;
					sstCnt_next = SST_LOAD;
				end
			end
			ST_SST: begin
				if (resetEvt) begin
					chipRst_next = 1'b1;
				end
				if (sstCnt_reg == 11'h000) begin
					state_next = ST_RUN;
					irqWake_next = 1'b0;
					// Calls wait a few cycles; plain resumes go at once.
					if (irqWake_reg) begin
						hold_next = CALL_HOLD;
					end else begin
						resume_next = 1'b1;
					end
				end else begin
					sstCnt_next = sstCnt_reg - 11'h001;
				end
			end
			default: state_next = ST_RUN;
		endcase
		intc_next[INTERRUPT_CONTROL_ONE_TBF] = intc_next[INTERRUPT_CONTROL_ONE_TBF] | tbSet;
		intc_next[INTERRUPT_CONTROL_ONE_RTF] = intc_next[INTERRUPT_CONTROL_ONE_RTF] | rtcSet;
		// Chip reset wipes the timers, interrupt state and divider choice.
		if (chipRst_next) begin
			wdt_next = '0;
			div_next = 15'h0000;
			rtc_control_next = RTC_CONTROL_RST;
			intc_next = INTERRUPT_CONTROL_ONE_RST;
			call_next = 1'b0;
			irqWake_next = 1'b0;
			hold_next = 2'h0;
		end
	end

	// Power-up lands in the start-up delay with both cause flags low.
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			state_reg <= ST_SST;
			sstCnt_reg <= SST_LOAD;
			wdt_reg <= '0;
			div_reg <= 15'h0000;
			to_reg <= 1'b0;
			pdf_reg <= 1'b0;
			rtc_control_reg <= RTC_CONTROL_RST;
			intc_reg <= INTERRUPT_CONTROL_ONE_RST;
			chipRst_reg <= 1'b0;
			warmRst_reg <= 1'b0;
			call_reg <= 1'b0;
			resume_reg <= 1'b0;
			vec_reg <= 8'h00;
			irqWake_reg <= 1'b0;
			hold_reg <= 2'h0;
		end else begin
			state_reg <= state_next;
			sstCnt_reg <= sstCnt_next;
			wdt_reg <= wdt_next;
			div_reg <= div_next;
			to_reg <= to_next;
			pdf_reg <= pdf_next;
			rtc_control_reg <= rtc_control_next;
			intc_reg <= intc_next;
			chipRst_reg <= chipRst_next;
			warmRst_reg <= warmRst_next;
			call_reg <= call_next;
			resume_reg <= resume_next;
			vec_reg <= vec_next;
			irqWake_reg <= irqWake_next;
			hold_reg <= hold_next;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (srst);

	sequence haltEntry;
		state_reg == ST_RUN && haltCmd && !resetEvt && !wdtOvf;
	endsequence
	sequence sstDone;
		state_reg == ST_SST && sstCnt_reg == 11'h000 && !resetEvt;
	endsequence

	chk_sst_load: assert property (
		state_reg == ST_HALT && state_next == ST_SST
		|=> sstCnt_reg == SST_LOAD)
		else $error("start-up count not loaded on wake");
	chk_sst_exit: assert property (sstDone |=> cpuRun)
		else $error("start-up delay did not end in run");
	chk_halt_flags: assert property (
		haltEntry |=> pdf_reg && !to_reg && ioHold && wdt_reg == '0)
		else $error("halt entry flags wrong");
	chk_osc_stop: assert property (haltEntry |=> !sysOscRun)
		else $error("system oscillator still on in halt");
	chk_tb_flag: assert property (
		tbSet && !chipRst_next |=> intc_reg[INTERRUPT_CONTROL_ONE_TBF])
		else $error("timebase flag not set");
	chk_rtc_flag: assert property (
		rtcSet && !chipRst_next |=> intc_reg[INTERRUPT_CONTROL_ONE_RTF])
		else $error("rtc flag not set");
	chk_stale_wake: assert property (
		state_reg == ST_HALT && !paWake && !extIrqEvent && !resetEvt
		&& !wdtOvf && !(tbSet && !intc_reg[INTERRUPT_CONTROL_ONE_TBF])
		&& !(rtcSet && !intc_reg[INTERRUPT_CONTROL_ONE_RTF])
		|=> state_reg == ST_HALT)
		else $error("halt left without a fresh event");
	chk_warm_reset: assert property (
		state_reg == ST_HALT && wdtOvf && !resetEvt
		|=> warmReset && !chipReset && to_reg && pdf_reg)
		else $error("watchdog wake not a warm reset");
	chk_wdt_chip: assert property (
		state_reg == ST_RUN && wdtOvf && !resetEvt
		|=> chipReset && to_reg && $stable(pdf_reg))
		else $error("watchdog run timeout wrong");
	chk_clr_pdf: assert property (
		clrCmd && !haltCmd |=> !pdf_reg)
		else $error("clear watchdog left power-down flag");
	chk_call_delay: assert property (
		sstDone ##0 irqWake_reg |=> !irqCall [*2])
		else $error("interrupt call came too soon after wake");
endmodule : hwrt_halt_wake_reset
`default_nettype wire

//--- hwrt_halt_wake_reset_tb_top.sv
// Self-checking bench for the halt, wake-up, reset and timebase block.
// Assumes the block's package, a 40 MHz ref_clk and no partner model.
`timescale 1ns/1ps
`default_nettype none
module hwrt_halt_wake_reset_tb_top;
	import hwrt_pkg::*;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic externalResetPinN = 1'b1;
	logic [7:0] portAPins = 8'hFF;
	logic extIrqEvent = 1'b0;
	logic globalIrqEn = 1'b0;
	logic stackFull = 1'b0;
	logic slowTick = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, sysOscRun, lcdClkRun, cpuRun, ioHold;
	logic chipReset, warmReset, resumeNext, irqCall;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [7:0] irqVector;
	int failCount = 0;
	int testsRun = 0;
	int cycles = 0;

	hwrt_halt_wake_reset uut (.ref_clk, .srst, .externalResetPinN,
		.portAPins, .extIrqEvent, .globalIrqEn, .stackFull, .slowTick,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .sysOscRun, .lcdClkRun, .cpuRun, .ioHold,
		.chipReset, .warmReset, .resumeNext, .irqCall, .irqVector);

	// The clock toggles every half period of 12.5 ns.
	always #12.5 ref_clk = ~ref_clk;

	// A hang is cut short well after the longest expected run.
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 100000) begin
			failCount++;
			results();
		end
	end

	task automatic results();
		if (failCount == 0 && testsRun > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : results

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		testsRun++;
		if (seen !== exp) begin
			failCount++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	function automatic logic [31:0] inr(int v, int lo, int hi);
		return {31'h0000_0000, v >= lo && v <= hi};
	endfunction : inr

	// Handshakes are sampled at the falling edge, so the rising edge that
	// completes them is never raced against the design's own updates.
	task automatic wr(input logic [7:0] a, d, input logic [1:0] er);
		logic ad, wd, b;
		logic [1:0] r;
		ad = 1'b0;
		wd = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h00_0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(ad && wd)) begin
			@(negedge ref_clk);
			if (s_axi_awvalid && s_axi_awready) ad = 1'b1;
			if (s_axi_wvalid && s_axi_wready) wd = 1'b1;
			@(posedge ref_clk);
			if (ad) s_axi_awvalid <= 1'b0;
			if (wd) s_axi_wvalid <= 1'b0;
		end
		do begin
			@(negedge ref_clk);
			b = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge ref_clk);
		end while (b !== 1'b1);
		chk("write response", {30'h0000_0000, r}, {30'h0000_0000, er});
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [1:0] er);
		logic v;
		logic [31:0] d;
		logic [1:0] r;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge ref_clk);
			v = s_axi_arready;
			@(posedge ref_clk);
		end while (v !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do begin
			@(negedge ref_clk);
			v = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge ref_clk);
		end while (v !== 1'b1);
		chk("read data", d, e);
		chk("read response", {30'h0000_0000, r}, {30'h0000_0000, er});
	endtask : rd

	task automatic halt();
		wr(ADDR_CMD, 8'h01, RESP_OKAY);
		repeat (2) @(posedge ref_clk);
	endtask : halt

	// Holds slowTick for n ticks, counting calls and the first warm reset.
	task automatic ticks(input int n, output int tb, rt, w);
		tb = 0;
		rt = 0;
		w = 0;
		slowTick <= 1'b1;
		for (int i = 1; i <= n + 4; i++) begin
			@(negedge ref_clk);
			if (irqCall === 1'b1 && irqVector === VEC_TB) tb++;
			if (irqCall === 1'b1 && irqVector === VEC_RTC) rt++;
			if (warmReset === 1'b1 && w == 0) w = i;
			@(posedge ref_clk);
			if (i == n) slowTick <= 1'b0;
		end
	endtask : ticks

	// Counts edges until cpuRun, then watches resumeNext and irqCall.
	task automatic waitRun(output int n, k, output logic rn,
		output logic [7:0] v);
		n = 0;
		k = 0;
		rn = 1'b0;
		v = 8'h00;
		do begin
			@(posedge ref_clk);
			n++;
			@(negedge ref_clk);
		end while (cpuRun !== 1'b1);
		for (int i = 0; i < 8; i++) begin
			if (i > 0) begin
				@(posedge ref_clk);
				@(negedge ref_clk);
			end
			if (i < 2 && resumeNext === 1'b1) rn = 1'b1;
			if (k == 0 && irqCall === 1'b1) begin
				k = i + 1;
				v = irqVector;
			end
		end
		@(posedge ref_clk);
	endtask : waitRun

	// Main sequence; the rtc loop clears the watchdog before every run.
	initial begin
		int n, k, tb, rt, w;
		logic rn;
		logic [7:0] v;
		repeat (6) @(posedge ref_clk);
		srst <= 1'b0;
		waitRun(n, k, rn, v);
		chk("power delay", inr(n, 1024, 1026), 1);
		rd(ADDR_STAT, 32'h0000_0000, RESP_OKAY);
		rd(ADDR_RTC_CONTROL, 32'h0000_0007, RESP_OKAY);
		rd(ADDR_INTERRUPT_CONTROL_ONE, 32'h0000_0000, RESP_OKAY);
		wr(8'hFC, 8'h5A, RESP_SLVERR);
		rd(8'hFC, 32'h0000_0000, RESP_SLVERR);
		globalIrqEn <= 1'b1;
		wr(ADDR_INTERRUPT_CONTROL_ONE, 8'h04, RESP_OKAY);
		for (int s = 0; s < 5; s++) begin
			wr(ADDR_RTC_CONTROL, 8'(s), RESP_OKAY);
			wr(ADDR_CMD, 8'h02, RESP_OKAY);
			ticks(4096, tb, rt, w);
			chk("rtc calls", rt, 32'(16 >> s));
			chk("timebase off", tb, 0);
		end
		// A full stack holds the timebase call back; the flag must wait.
		stackFull <= 1'b1;
		wr(ADDR_INTERRUPT_CONTROL_ONE, 8'h02, RESP_OKAY);
		wr(ADDR_CMD, 8'h02, RESP_OKAY);
		ticks(4096, tb, rt, w);
		chk("timebase held", tb, 0);
		rd(ADDR_INTERRUPT_CONTROL_ONE, 32'h0000_0062, RESP_OKAY);
		stackFull <= 1'b0;
		ticks(4096, tb, rt, w);
		chk("timebase calls", tb, 2);
		// Flags already set before halt, so only the watchdog may wake.
		globalIrqEn <= 1'b0;
		wr(ADDR_INTERRUPT_CONTROL_ONE, 8'h66, RESP_OKAY);
		halt();
		@(negedge ref_clk);
		chk("halt outs", {28'h000_0000, sysOscRun, lcdClkRun, cpuRun,
			ioHold}, 32'h0000_0005);
		@(posedge ref_clk);
		rd(ADDR_STAT, 32'h0000_0006, RESP_OKAY);
		ticks(32772, tb, rt, w);
		chk("watchdog wake", inr(w, 32768, 32772), 1);
		waitRun(n, k, rn, v);
		rd(ADDR_STAT, 32'h0000_0003, RESP_OKAY);
		rd(ADDR_INTERRUPT_CONTROL_ONE, 32'h0000_0066, RESP_OKAY);
		externalResetPinN <= 1'b0;
		@(posedge ref_clk);
		externalResetPinN <= 1'b1;
		@(negedge ref_clk);
		chk("chip reset", {31'h0000_0000, chipReset}, 1);
		@(posedge ref_clk);
		rd(ADDR_STAT, 32'h0000_0003, RESP_OKAY);
		rd(ADDR_RTC_CONTROL, 32'h0000_0007, RESP_OKAY);
		// A write with lane 0 strobed off must leave the register alone.
		s_axi_wstrb <= 4'h0;
		wr(ADDR_RTC_CONTROL, 8'h05, RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		rd(ADDR_RTC_CONTROL, 32'h0000_0007, RESP_OKAY);
		wr(ADDR_CMD, 8'h02, RESP_OKAY);
		rd(ADDR_STAT, 32'h0000_0001, RESP_OKAY);
		halt();
		externalResetPinN <= 1'b0;
		@(posedge ref_clk);
		externalResetPinN <= 1'b1;
		waitRun(n, k, rn, v);
		chk("reset wake", inr(n, 1023, 1028), 1);
		rd(ADDR_STAT, 32'h0000_0002, RESP_OKAY);
		// Every port A bit wakes on its own falling edge.
		for (int b = 0; b < 8; b++) begin
			halt();
			portAPins <= ~(8'h01 << b);
			waitRun(n, k, rn, v);
			portAPins <= 8'hFF;
			chk("port wake", inr(n, 1024, 1032), 1);
			chk("port resume", {31'h0000_0000, rn}, 1);
		end
		halt();
		extIrqEvent <= 1'b1;
		@(posedge ref_clk);
		extIrqEvent <= 1'b0;
		waitRun(n, k, rn, v);
		chk("irq resume", {31'h0000_0000, rn}, 1);
		// An enabled timebase event wakes the core into its call.
		globalIrqEn <= 1'b1;
		wr(ADDR_INTERRUPT_CONTROL_ONE, 8'h02, RESP_OKAY);
		halt();
		slowTick <= 1'b1;
		do begin
			@(negedge ref_clk);
			rn = ioHold;
			@(posedge ref_clk);
		end while (rn === 1'b1);
		slowTick <= 1'b0;
		waitRun(n, k, rn, v);
		chk("call no resume", {31'h0000_0000, rn}, 0);
		chk("call delay", inr(k, 3, 8), 1);
		chk("call vector", {24'h00_0000, v}, 32'h0000_0014);
		results();
	end
endmodule : hwrt_halt_wake_reset_tb_top
`default_nettype wire
